// ==== src/vipu_map.svh ====
`ifndef VIPU_MAP_SVH
`define VIPU_MAP_SVH

`define VIPU_AW          4
`define VIPU_DW          16
`define VIPU_A_STAT      4'h0
`define VIPU_A_MASK      4'h1
`define VIPU_A_PRIO      4'h2
`define VIPU_A_MODE      4'h3
`define VIPU_A_FILT      4'h4
`define VIPU_A_INSVC     4'h5

`define VIPU_RST_MASK    16'h0000
`define VIPU_RST_PRIO    10'h000
`define VIPU_RST_MODE    8'h00
`define VIPU_RST_FILT    3'h0

`define VIPU_MODE0_LSB   0
`define VIPU_MODE1_LSB   2
`define VIPU_MODE2_LSB   4
`define VIPU_MODE3_LSB   6
`define VIPU_FILT_SEL_LSB 0
`define VIPU_FILT_POL_BIT 2

`define VIPU_SRC_EXT0    0
`define VIPU_SRC_EXT1    1
`define VIPU_SRC_EXT2    2
`define VIPU_SRC_TLO     3
`define VIPU_SRC_EXT3    4
`define VIPU_SRC_BASE    5
`define VIPU_SRC_PORT0   15

`define VIPU_VEC_BASE    8'h03
`define VIPU_VEC_STEP    8'h08
`define VIPU_DIV16_END   6'h0F
`define VIPU_DIV64_END   6'h3F

`endif

// ==== src/vipu_pkg.sv ====
package vipu_pkg;

	typedef enum logic [2:0] {
		SBY_RUN  = 3'b001,
		SBY_HALT = 3'b010,
		SBY_HOLD = 3'b100
	} vipu_sby_t;

	typedef enum logic [1:0] {
		LVL_LOW  = 2'h0,
		LVL_HIGH = 2'h1,
		LVL_TOP  = 2'h2
	} vipu_lvl_t;

	typedef enum logic [1:0] {
		FSEL_DIV1  = 2'h0,
		FSEL_DIV16 = 2'h1,
		FSEL_DIV64 = 2'h2,
		FSEL_OFF   = 2'h3
	} vipu_fsel_t;

endpackage

// ==== src/vipu_filt_if.sv ====
`timescale 1ns/10ps
interface vipu_filt_if;
	logic raw;
	logic pol;
	logic tick;
	logic bypass;
	logic clean;

	modport ctl  (output raw, output pol, output tick, output bypass, input clean);
	modport filt (input raw, input pol, input tick, input bypass, output clean);
endinterface

// ==== src/vipu_filt.sv ====
`timescale 1ns/10ps
module vipu_filt (
	input  wire logic  sys_clk_i,
	input  wire logic  rst_i,
	vipu_filt_if.filt  fif
);
	logic samp;
	logic s1_r;
	logic clean_r;

	// Polarity is applied before filtering so the edge logic always sees the true sense.
	assign samp      = fif.raw ^ fif.pol;
	assign fif.clean = clean_r;

	// Outside bypass, two agreeing samples at the chosen rate are needed, so a glitch shorter than one
	// sample period never reaches the edge detector.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r    <= 1'b0;
			clean_r <= 1'b0;
		end else if (fif.bypass) begin
			s1_r    <= samp;
			clean_r <= samp;
		end else if (fif.tick) begin
			s1_r <= samp;
			if (s1_r == samp) begin
				clean_r <= samp;
			end
		end
	end
endmodule

// ==== src/vipu_top.sv ====
`timescale 1ns/10ps
`include "vipu_map.svh"
module vipu_top (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [`VIPU_AW-1:0]   reg_addr_i,
	input  wire logic [`VIPU_DW-1:0]   reg_wdata_i,
	input  wire logic                  reg_we_i,
	input  wire logic                  reg_re_i,
	output logic      [`VIPU_DW-1:0]   reg_rdata_o,
	input  wire logic                  ext_req_zero_i,
	input  wire logic                  ext_req_one_i,
	input  wire logic                  ext_req_two_i,
	input  wire logic                  ext_req_three_i,
	input  wire logic                  reset_pin_n_i,
	input  wire logic                  port0_cond_i,
	input  wire logic [10:0]           periph_evt_i,
	input  wire logic                  halt_cmd_i,
	input  wire logic                  hold_cmd_i,
	input  wire logic                  vec_ack_i,
	input  wire logic                  vec_reti_i,
	output logic                       irq_o,
	output logic                       vec_req_o,
	output logic      [7:0]            vec_addr_o,
	output logic      [1:0]            vec_lvl_o,
	output logic                       halted_o,
	output logic                       held_o
);
	logic [15:0]          stat_r;
	logic [15:0]          stat_nxt;
	logic [15:0]          stat_set;
	logic [15:0]          stat_clr;
	logic [15:0]          mask_r;
	logic [15:0]          pend;
	logic [9:0]           prio_r;
	logic [7:0]           mode_r;
	logic [2:0]           filt_r;
	logic [2:0]           insvc_r;
	logic [2:0]           insvc_nxt;
	logic [3:0]           pin_d_r;
	logic [5:0]           div_r;
	logic [15:0]          rdata_r;
	logic [15:0]          rd_mux;
	logic [9:0]           vec_pend;
	logic [3:0]           best_idx;
	logic [1:0]           best_lvl;
	logic                 best_ok;
	logic [1:0]           cur_lvl;
	logic                 any_insvc;
	logic                 grant;
	logic                 vec_req_r;
	logic [3:0]           vec_idx_r;
	logic [7:0]           vec_addr_r;
	logic [1:0]           vec_lvl_r;
	logic                 hold_wake;
	logic                 ext0_hit;
	logic                 ext1_hit;
	logic                 ext2_hit;
	logic                 ext3_hit;
	logic                 ext3_clean;
	logic                 tick16;
	logic                 tick64;
	logic                 wr_stat;
	vipu_pkg::vipu_sby_t  sby_r;
	vipu_pkg::vipu_sby_t  sby_nxt;
	vipu_pkg::vipu_fsel_t fsel;

	vipu_filt_if fif ();

	// Lines zero and one: 0 rise, 1 fall, 2 high level, 3 low level; no both-edge code.
	function automatic logic lvl_hit(input logic [1:0] m, input logic cur, input logic prv);
		unique case (m)
			2'h0:    lvl_hit = cur & ~prv;
			2'h1:    lvl_hit = ~cur & prv;
			2'h2:    lvl_hit = cur;
			default: lvl_hit = ~cur;
		endcase
	endfunction

	// Lines two and three: 0 rise, 1 fall, 2 or 3 both edges; no level mode exists.
	function automatic logic edge_hit(input logic [1:0] m, input logic cur, input logic prv);
		unique case (m)
			2'h0:    edge_hit = cur & ~prv;
			2'h1:    edge_hit = ~cur & prv;
			default: edge_hit = cur ^ prv;
		endcase
	endfunction

	// The priority bit has a different meaning below and above vector index two.
	function automatic logic [1:0] vec_level(input logic [3:0] i, input logic [9:0] p);
		if (i < 4'h2) begin
			vec_level = p[i] ? vipu_pkg::LVL_TOP : vipu_pkg::LVL_HIGH;
		end else begin
			vec_level = p[i] ? vipu_pkg::LVL_HIGH : vipu_pkg::LVL_LOW;
		end
	endfunction

	function automatic logic [7:0] vec_addr(input logic [3:0] i);
		vec_addr = `VIPU_VEC_BASE + (8'(i) << 3);
	endfunction

	assign tick16 = {2'h0, div_r[3:0]} == `VIPU_DIV16_END;
	assign tick64 = div_r == `VIPU_DIV64_END;
	assign fsel   = vipu_pkg::vipu_fsel_t'(filt_r[`VIPU_FILT_SEL_LSB +: 2]);

	assign fif.raw    = ext_req_three_i;
	assign fif.pol    = filt_r[`VIPU_FILT_POL_BIT];
	assign fif.bypass = fsel == vipu_pkg::FSEL_OFF;
	assign fif.tick   = (fsel == vipu_pkg::FSEL_DIV1) ? 1'b1 :
	                    (fsel == vipu_pkg::FSEL_DIV16) ? tick16 : tick64;
	assign ext3_clean = fif.clean;

	vipu_filt u_filt (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.fif       (fif)
	);

	assign ext0_hit = lvl_hit(mode_r[`VIPU_MODE0_LSB +: 2], ext_req_zero_i, pin_d_r[0]);
	assign ext1_hit = lvl_hit(mode_r[`VIPU_MODE1_LSB +: 2], ext_req_one_i, pin_d_r[1]);
	assign ext2_hit = edge_hit(mode_r[`VIPU_MODE2_LSB +: 2], ext_req_two_i, pin_d_r[2]);
	assign ext3_hit = edge_hit(mode_r[`VIPU_MODE3_LSB +: 2], ext3_clean, pin_d_r[3]);

	// Sixteen sticky sources; peripherals arrive as one-cycle pulses.
	assign stat_set = {port0_cond_i, periph_evt_i[10:2], periph_evt_i[1], ext3_hit,
	                   periph_evt_i[0], ext2_hit, ext1_hit, ext0_hit};
	assign wr_stat  = reg_we_i && (reg_addr_i == `VIPU_A_STAT);
	assign stat_clr = wr_stat ? reg_wdata_i : 16'h0000;
	// A source firing in the cycle its bit is cleared keeps the bit set.
	assign stat_nxt = (stat_r & ~stat_clr) | stat_set;
	assign pend     = stat_r & mask_r;
	assign irq_o    = |pend;

	assign vec_pend[0] = pend[0];
	assign vec_pend[1] = pend[1];
	assign vec_pend[2] = pend[2] | pend[3];
	assign vec_pend[3] = pend[4] | pend[5];
	assign vec_pend[4] = pend[6];
	assign vec_pend[5] = pend[7] | pend[8];
	assign vec_pend[6] = pend[9];
	assign vec_pend[7] = pend[10];
	assign vec_pend[8] = pend[11] | pend[12] | pend[13];
	assign vec_pend[9] = pend[14] | pend[15];

	// Strictly greater replaces, so at equal level the lowest index stays chosen.
	always_comb begin
		best_idx = 4'h0;
		best_lvl = vipu_pkg::LVL_LOW;
		best_ok  = 1'b0;
		for (int i = 0; i < 10; i++) begin
			if (vec_pend[i] && (!best_ok || vec_level(4'(i), prio_r) > best_lvl)) begin
				best_idx = 4'(i);
				best_lvl = vec_level(4'(i), prio_r);
				best_ok  = 1'b1;
			end
		end
	end

	assign any_insvc = |insvc_r;
	assign cur_lvl   = insvc_r[2] ? vipu_pkg::LVL_TOP :
	                   insvc_r[1] ? vipu_pkg::LVL_HIGH : vipu_pkg::LVL_LOW;
	assign grant     = best_ok && (!any_insvc || best_lvl > cur_lvl);

	// Return drops the deepest level first, then a new acceptance is recorded.
	always_comb begin
		insvc_nxt = insvc_r;
		if (vec_reti_i) begin
			if (insvc_r[2]) begin
				insvc_nxt[2] = 1'b0;
			end else if (insvc_r[1]) begin
				insvc_nxt[1] = 1'b0;
			end else begin
				insvc_nxt[0] = 1'b0;
			end
		end
		if (vec_ack_i && vec_req_r) begin
			insvc_nxt[vec_lvl_r] = 1'b1;
		end
	end

	assign hold_wake = !reset_pin_n_i
	                || (mode_r[`VIPU_MODE0_LSB + 1] && ext0_hit)
	                || (mode_r[`VIPU_MODE1_LSB + 1] && ext1_hit)
	                || port0_cond_i;

	always_comb begin
		sby_nxt = sby_r;
		unique case (sby_r)
			vipu_pkg::SBY_RUN: begin
				if (hold_cmd_i) begin
					sby_nxt = vipu_pkg::SBY_HOLD;
				end else if (halt_cmd_i) begin
					sby_nxt = vipu_pkg::SBY_HALT;
				end
			end
			vipu_pkg::SBY_HALT: begin
				if (grant) begin
					sby_nxt = vipu_pkg::SBY_RUN;
				end
			end
			vipu_pkg::SBY_HOLD: begin
				if (hold_wake) begin
					sby_nxt = vipu_pkg::SBY_RUN;
				end
			end
			default: sby_nxt = vipu_pkg::SBY_RUN;
		endcase
	end

	always_comb begin
		unique case (reg_addr_i)
			`VIPU_A_STAT:  rd_mux = stat_r;
			`VIPU_A_MASK:  rd_mux = mask_r;
			`VIPU_A_PRIO:  rd_mux = {6'h00, prio_r};
			`VIPU_A_MODE:  rd_mux = {8'h00, mode_r};
			`VIPU_A_FILT:  rd_mux = {13'h0000, filt_r};
			`VIPU_A_INSVC: rd_mux = {10'h000, sby_r, insvc_r};
			default:       rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_r  <= 16'h0000;
			mask_r  <= `VIPU_RST_MASK;
			prio_r  <= `VIPU_RST_PRIO;
			mode_r  <= `VIPU_RST_MODE;
			filt_r  <= `VIPU_RST_FILT;
			rdata_r <= 16'h0000;
		end else begin
			stat_r  <= stat_nxt;
			rdata_r <= reg_re_i ? rd_mux : 16'h0000;
			if (reg_we_i && reg_addr_i == `VIPU_A_MASK) begin
				mask_r <= reg_wdata_i;
			end
			if (reg_we_i && reg_addr_i == `VIPU_A_PRIO) begin
				prio_r <= reg_wdata_i[9:0];
			end
			if (reg_we_i && reg_addr_i == `VIPU_A_MODE) begin
				mode_r <= reg_wdata_i[7:0];
			end
			if (reg_we_i && reg_addr_i == `VIPU_A_FILT) begin
				filt_r <= reg_wdata_i[2:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_d_r <= 4'h0;
			div_r   <= 6'h00;
			insvc_r <= 3'h0;
			sby_r   <= vipu_pkg::SBY_RUN;
		end else begin
			pin_d_r <= {ext3_clean, ext_req_two_i, ext_req_one_i, ext_req_zero_i};
			div_r   <= div_r + 6'h01;
			insvc_r <= insvc_nxt;
			sby_r   <= sby_nxt;
		end
	end

	// The request drops in the cycle after acceptance, the same cycle the new nesting level shows.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			vec_req_r  <= 1'b0;
			vec_idx_r  <= 4'h0;
			vec_addr_r <= 8'h00;
			vec_lvl_r  <= 2'h0;
		end else begin
			vec_req_r  <= grant && !(vec_ack_i && vec_req_r);
			vec_idx_r  <= best_idx;
			vec_addr_r <= vec_addr(best_idx);
			vec_lvl_r  <= best_lvl;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign vec_req_o   = vec_req_r;
	assign vec_addr_o  = vec_addr_r;
	assign vec_lvl_o   = vec_lvl_r;
	assign halted_o    = sby_r == vipu_pkg::SBY_HALT;
	assign held_o      = sby_r == vipu_pkg::SBY_HOLD;

	property p_share_tlo;
		@(posedge sys_clk_i) disable iff (rst_i)
		periph_evt_i[0] && mask_r[3] |=> stat_r[3] && vec_pend[2];
	endproperty
	a_share_tlo: assert property (p_share_tlo) else $error("timer low off vector three");

	property p_share_base;
		@(posedge sys_clk_i) disable iff (rst_i)
		periph_evt_i[1] && mask_r[5] |=> stat_r[5] && vec_pend[3];
	endproperty
	a_share_base: assert property (p_share_base) else $error("base timer off vector four");

	property p_ext_addr;
		@(posedge sys_clk_i) disable iff (rst_i)
		vec_req_o && vec_idx_r < 4'h4 |-> vec_addr_o == 8'(8'h03 + 8'(vec_idx_r) * 8);
	endproperty
	a_ext_addr: assert property (p_ext_addr) else $error("wrong external vector address");

	property p_nest;
		@(posedge sys_clk_i) disable iff (rst_i)
		vec_req_o && $past(vec_req_o) |-> !any_insvc || vec_lvl_o > cur_lvl;
	endproperty
	a_nest: assert property (p_nest) else $error("request not above service level");

	property p_low_vecs;
		@(posedge sys_clk_i) disable iff (rst_i)
		vec_req_o && vec_idx_r >= 4'h2 |-> vec_lvl_o != vipu_pkg::LVL_TOP;
	endproperty
	a_low_vecs: assert property (p_low_vecs) else $error("shared vector at top level");

	property p_ext01_lvl;
		@(posedge sys_clk_i) disable iff (rst_i)
		vec_req_o && vec_idx_r < 4'h2 |-> vec_lvl_o != vipu_pkg::LVL_LOW;
	endproperty
	a_ext01_lvl: assert property (p_ext01_lvl) else $error("line zero or one at low");

	property p_ext1_low;
		@(posedge sys_clk_i) disable iff (rst_i)
		mode_r[3:2] == 2'h3 && !ext_req_one_i |=> stat_r[1];
	endproperty
	a_ext1_low: assert property (p_ext1_low) else $error("low level on line one missed");

	property p_ext2_both;
		@(posedge sys_clk_i) disable iff (rst_i)
		mode_r[5:4] == 2'h2 && $changed(ext_req_two_i) && !wr_stat |=> stat_r[2];
	endproperty
	a_ext2_both: assert property (p_ext2_both) else $error("both-edge on line two missed");

	property p_halt_wake;
		@(posedge sys_clk_i) disable iff (rst_i)
		sby_r == vipu_pkg::SBY_HALT && grant |=> sby_r == vipu_pkg::SBY_RUN ##1 vec_req_o;
	endproperty
	a_halt_wake: assert property (p_halt_wake) else $error("halt not left on request");

	property p_hold_wake;
		@(posedge sys_clk_i) disable iff (rst_i)
		sby_r == vipu_pkg::SBY_HOLD && !reset_pin_n_i |=> !held_o;
	endproperty
	a_hold_wake: assert property (p_hold_wake) else $error("hold not left on reset pin");
endmodule

// ==== verif/vipu_core_model.sv ====
`timescale 1ns/10ps
// Core side of the vector link. It takes an offered vector after a set wait and
// returns from service only when told, never more often than it has taken.
module vipu_core_model (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       vec_req_i,
	input  wire logic [3:0] ack_wait_i,
	input  wire logic       reti_go_i,
	output logic            vec_ack_o,
	output logic            vec_reti_o,
	output logic [3:0]      depth_o
);
	logic [3:0] wait_r;
	wire        take = vec_ack_o & vec_req_i;
	wire        back = reti_go_i & ~vec_reti_o & (depth_o != 4'h0);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			vec_ack_o  <= 1'b0;
			vec_reti_o <= 1'b0;
			depth_o    <= 4'h0;
			wait_r     <= 4'h0;
		end else begin
			vec_ack_o  <= ~take & vec_req_i & (wait_r >= ack_wait_i);
			wait_r     <= (take | ~vec_req_i) ? 4'h0 : wait_r + 4'h1;
			vec_reti_o <= back;
			depth_o    <= depth_o + {3'h0, take} - {3'h0, back};
		end
	end
endmodule

// ==== verif/test_vectored_interrupt_priority_unit.sv ====
`timescale 1ns/10ps
`include "vipu_map.svh"
module test_vectored_interrupt_priority_unit;
	logic        sys_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_we_i = 1'b0;
	logic        reg_re_i = 1'b0;
	logic [3:0]  pin = 4'h0;
	logic        reset_pin_n_i = 1'b1;
	logic        port0_cond_i = 1'b0;
	logic [10:0] periph_evt_i = 11'h000;
	logic        halt_cmd_i = 1'b0;
	logic        hold_cmd_i = 1'b0;
	logic        reti_go = 1'b0;
	logic [3:0]  ack_wait = 4'h0;
	logic [15:0] reg_rdata_o;
	logic        vec_ack_i, vec_reti_i, irq_o, vec_req_o, halted_o, held_o;
	logic [7:0]  vec_addr_o;
	logic [1:0]  vec_lvl_o;
	logic [3:0]  depth;
	logic [9:0]  vec_q[$];
	logic [15:0] rd_q[$];
	logic        re_d = 1'b0;
	logic [9:0]  prio = 10'h000;
	int          n_errors = 0;
	int          n_compared = 0;
	int          seed = 59;

	always #25 sys_clk_i = ~sys_clk_i;

	vipu_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .ext_req_zero_i(pin[0]), .ext_req_one_i(pin[1]),
		.ext_req_two_i(pin[2]), .ext_req_three_i(pin[3]), .reset_pin_n_i(reset_pin_n_i),
		.port0_cond_i(port0_cond_i), .periph_evt_i(periph_evt_i), .halt_cmd_i(halt_cmd_i),
		.hold_cmd_i(hold_cmd_i), .vec_ack_i(vec_ack_i), .vec_reti_i(vec_reti_i),
		.irq_o(irq_o), .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o),
		.vec_lvl_o(vec_lvl_o), .halted_o(halted_o), .held_o(held_o));

	vipu_core_model core (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .vec_req_i(vec_req_o),
		.ack_wait_i(ack_wait), .reti_go_i(reti_go), .vec_ack_o(vec_ack_i),
		.vec_reti_o(vec_reti_i), .depth_o(depth));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Expected vector for a status bit: shared vectors follow the source grouping.
	function automatic logic [9:0] vexp(input int b);
		int v;
		v = (b < 2) ? b : (b < 4) ? 2 : (b < 6) ? 3 : (b < 7) ? 4 : (b < 9) ? 5 :
			(b < 11) ? b - 3 : (b < 14) ? 8 : 9;
		return {8'(8'h03 + 8 * v), (v < 2) ? {prio[v], ~prio[v]} : {1'b0, prio[v]}};
	endfunction

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_we_i    <= w;
		reg_re_i    <= ~w;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_we_i <= 1'b0;
		reg_re_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		rd_q.push_back(exp);
		bus(1'b0, a, 16'h0000);
	endtask

	// A missing vector shows up as a depth that never arrives.
	task automatic take(input logic [3:0] n);
		int k = 0;
		while (depth !== n && k < 200) begin
			@(posedge sys_clk_i);
			k++;
		end
		if (depth !== n) begin
			check("depth", {12'h000, depth}, {12'h000, n});
			print_verdict();
		end
	endtask

	// Status must be cleared before the return, or the source asks again.
	task automatic done(input logic [15:0] st, input logic [3:0] n);
		bus(1'b1, `VIPU_A_STAT, st);
		@(posedge sys_clk_i);
		reti_go <= 1'b1;
		@(posedge sys_clk_i);
		reti_go <= 1'b0;
		take(n);
	endtask

	task automatic ev(input logic [10:0] m);
		@(posedge sys_clk_i);
		periph_evt_i <= m;
		@(posedge sys_clk_i);
		periph_evt_i <= 11'h000;
	endtask

	task automatic drive(input int k, input logic v);
		@(posedge sys_clk_i);
		pin[k] <= v;
		cycles(3);
	endtask

	task automatic sby(input logic h);
		@(posedge sys_clk_i);
		halt_cmd_i <= ~h;
		hold_cmd_i <= h;
		@(posedge sys_clk_i);
		halt_cmd_i <= 1'b0;
		hold_cmd_i <= 1'b0;
		cycles(2);
	endtask

	always @(posedge sys_clk_i) begin
		if (re_d)
			check("rdata", reg_rdata_o, rd_q.pop_front());
		re_d = reg_re_i;
		if (vec_ack_i === 1'b1 && vec_req_o === 1'b1)
			check("vector", {6'h00, vec_addr_o, vec_lvl_o}, vec_q.pop_front());
	end

	initial begin
		cycles(4);
		rst_i <= 1'b0;
		for (int i = 0; i < 16; i++)
			rd(4'(i), (i == 5) ? 16'h0008 : 16'h0000);
		bus(1'b1, `VIPU_A_INSVC, 16'hFFFF);
		rd(`VIPU_A_INSVC, 16'h0008);
		// The event lands while masked; the request must wait for the mask write.
		bus(1'b1, `VIPU_A_MASK, 16'h0000);
		ev(11'h004);
		cycles(4);
		check("masked req", {15'h0, vec_req_o}, 16'h0000);
		rd(`VIPU_A_STAT, 16'h0040);
		prio = 10'($random(seed));
		bus(1'b1, `VIPU_A_PRIO, {6'h00, prio});
		rd(`VIPU_A_PRIO, {6'h00, prio});
		bus(1'b1, `VIPU_A_MASK, 16'h0040);
		cycles(1);
		check("irq", {15'h0, irq_o}, 16'h0001);
		vec_q.push_back(vexp(6));
		take(4'h1);
		done(16'h0040, 4'h0);
		check("irq", {15'h0, irq_o}, 16'h0000);
		bus(1'b1, `VIPU_A_MASK, 16'hFFFF);
		for (int j = 0; j < 11; j++) begin
			ack_wait <= 4'($unsigned($random(seed)) % 6);
			vec_q.push_back(vexp((j == 0) ? 3 : j + 4));
			ev(11'h001 << j);
			take(4'h1);
			rd(`VIPU_A_STAT, 16'h0001 << ((j == 0) ? 3 : j + 4));
			done(16'hFFFF, 4'h0);
		end
		bus(1'b1, `VIPU_A_MASK, 16'h0000);
		prio = 10'h001;
		bus(1'b1, `VIPU_A_PRIO, 16'h0001);
		bus(1'b1, `VIPU_A_MODE, 16'h0024);
		drive(1, 1'b1);
		// A one-cycle glitch must not pass the filter at the fastest rate.
		@(posedge sys_clk_i);
		pin[3] <= 1'b1;
		@(posedge sys_clk_i);
		pin[3] <= 1'b0;
		rd(`VIPU_A_STAT, 16'h0000);
		drive(3, 1'b1);
		rd(`VIPU_A_STAT, 16'h0010);
		bus(1'b1, `VIPU_A_FILT, 16'h0007);
		cycles(4);
		bus(1'b1, `VIPU_A_STAT, 16'hFFFF);
		bus(1'b1, `VIPU_A_MASK, 16'hFFFF);
		vec_q.push_back({8'h03, 2'h2});
		drive(0, 1'b1);
		take(4'h1);
		done(16'h0001, 4'h0);
		drive(0, 1'b0);
		vec_q.push_back({8'h0B, 2'h1});
		drive(1, 1'b0);
		take(4'h1);
		done(16'h0002, 4'h0);
		for (int e = 1; e >= 0; e--) begin
			vec_q.push_back({8'h13, 2'h0});
			drive(2, 1'(e));
			take(4'h1);
			done(16'h0004, 4'h0);
		end
		vec_q.push_back({8'h1B, 2'h0});
		drive(3, 1'b0);
		take(4'h1);
		done(16'h0010, 4'h0);
		vec_q.push_back({8'h13, 2'h0});
		ev(11'h001);
		take(4'h1);
		ev(11'h004);
		cycles(6);
		check("same level", {15'h0, vec_req_o}, 16'h0000);
		vec_q.push_back({8'h03, 2'h2});
		drive(0, 1'b1);
		take(4'h2);
		done(16'h0001, 4'h1);
		vec_q.push_back({8'h23, 2'h0});
		done(16'h0008, 4'h0);
		take(4'h1);
		done(16'h0040, 4'h0);
		vec_q.push_back({8'h1B, 2'h0});
		vec_q.push_back({8'h33, 2'h0});
		ev(11'h022);
		take(4'h1);
		done(16'h0020, 4'h0);
		take(4'h1);
		done(16'h0200, 4'h0);
		sby(1'b0);
		check("halted", {15'h0, halted_o}, 16'h0001);
		rd(`VIPU_A_INSVC, 16'h0010);
		vec_q.push_back({8'h23, 2'h0});
		ev(11'h004);
		take(4'h1);
		check("halted", {15'h0, halted_o}, 16'h0000);
		done(16'h0040, 4'h0);
		sby(1'b1);
		check("held", {15'h0, held_o}, 16'h0001);
		vec_q.push_back({8'h4B, 2'h0});
		@(posedge sys_clk_i);
		port0_cond_i <= 1'b1;
		cycles(2);
		port0_cond_i <= 1'b0;
		take(4'h1);
		check("held", {15'h0, held_o}, 16'h0000);
		done(16'h8000, 4'h0);
		sby(1'b1);
		reset_pin_n_i <= 1'b0;
		cycles(2);
		reset_pin_n_i <= 1'b1;
		cycles(1);
		check("held", {15'h0, held_o}, 16'h0000);
		cycles(2);
		// Low level on line one both wakes deep standby and requests its vector.
		sby(1'b1);
		check("held", {15'h0, held_o}, 16'h0001);
		vec_q.push_back({8'h0B, 2'h1});
		bus(1'b1, `VIPU_A_MODE, 16'h002C);
		take(4'h1);
		check("held", {15'h0, held_o}, 16'h0000);
		drive(1, 1'b1);
		done(16'h0002, 4'h0);
		print_verdict();
	end
endmodule
